// ### core/indicator_pkg.sv
package indicator_pkg;

  // ----------------------------------------------------------------
  // clock and blink timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned BLINK_HALF_MS  = 250;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;

  // ----------------------------------------------------------------
  // ports and network number range
  // ----------------------------------------------------------------
  localparam int unsigned PORTS_DEF   = 2;
  localparam int unsigned PORTS_MAX   = 8;
  localparam logic [7:0]  NET_NUM_MIN = 8'h01;
  localparam logic [7:0]  NET_NUM_MAX = 8'hEF;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 12;
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_SNAP    = 12'h008;
  localparam logic [31:0] RDATA_NONE   = 32'h00000000;

  localparam int unsigned CTRL_SYS_ERR   = 0;
  localparam int unsigned CTRL_SET_READY = 1;
  localparam int unsigned CTRL_SET_DONE  = 2;
  localparam int unsigned CTRL_NUM_SET   = 3;
  localparam int unsigned CTRL_NUM_LSB   = 8;

  localparam int unsigned STAT_LED_LSB  = 0;
  localparam int unsigned STAT_LERR_LSB = 8;
  localparam int unsigned STAT_LINK_LSB = 16;
  localparam int unsigned STAT_CHANGED  = 24;
  localparam int unsigned STAT_SETMODE  = 25;

  localparam int unsigned SNAP_STN_LSB = 0;
  localparam int unsigned SNAP_NET_LSB = 8;
  localparam int unsigned SNAP_MODE    = 16;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic power_on;
    logic run_ok;
    logic net_error;
    logic link_active;
    logic cyclic_run;
    logic comm_error;
    logic rx_active;
    logic tx_active;
  } net_status_s;

  typedef struct packed {
    logic [7:0] station;
    logic [7:0] netnum;
    logic       setting_mode;
  } switch_s;

  typedef struct packed {
    logic       sys_error;
    logic       setting_ready;
    logic       setting_done;
    logic       number_entered;
    logic [7:0] net_number;
  } ctrl_s;

  typedef struct packed {
    logic power_led;
    logic run_led;
    logic data_link_led;
    logic net_error_led;
    logic receive_activity_led;
    logic transmit_activity_led;
    logic system_status_led_a;
    logic system_status_led_b;
  } led_s;

endpackage

// ### core/blink_gen.sv
`timescale 1ns/100ps
module blink_gen #(
  parameter int unsigned HALF_CYC = indicator_pkg::BLINK_HALF_CYC
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  output logic      blink
);
  import indicator_pkg::*;

  localparam int unsigned W = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [W-1:0] CNT_LAST = W'(HALF_CYC - 1);
  localparam logic [W-1:0] CNT_ONE  = W'(1);

  // a one-cycle half period would toggle every edge, no visible flash
  if (HALF_CYC < 2) begin : g_bad_half
    $error("blink half period must be at least two cycles");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         phase;
  } blink_state_s;

  blink_state_s st;
  blink_state_s next_st;

  // ----------------------------------------------------------------
  // free-running prescaler, symmetric square wave
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (st.cnt == CNT_LAST) begin
      next_st.cnt   = '0;
      next_st.phase = ~st.phase;
    end else begin
      next_st.cnt = st.cnt + CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign blink = st.phase;

endmodule

// ### core/indicator_core.sv
// ----------------------------------------------------------------
// Contract
// - power LED follows network-side power.
// - run LED on while network normal, off on network error.
// - data-link LED steady on with link and cyclic transfer running.
// - data-link LED flashes with link up but cyclic transfer stopped.
// - data-link LED dark with no data link.
// - error LED steady on during communication error.
// - error LED flashes when any switch differs from its power-up value.
// - station switch sampled once at power-up only.
// - error LED dark when normal and nothing pending.
// - receive LED lit while frames are received.
// - transmit LED lit while frames are sent.
// - normal mode, status LED A on when healthy, off on system error.
// - setting mode, status LED A steady once setting completed.
// - setting mode, status LED A flashes when ready but not done.
// - normal mode, status LED B on only on system error.
// - setting mode, status LED B lit on out-of-range number.
// - per port, line-error LED set on bad data, cleared on good.
// - network number out of range below 1 or above 239.
// ----------------------------------------------------------------
`timescale 1ns/100ps
module indicator_core #(
  parameter int unsigned N_PORTS   = indicator_pkg::PORTS_DEF,
  parameter int unsigned BLINK_HALF = indicator_pkg::BLINK_HALF_CYC
) (
  input  wire logic                         clk_sys,
  input  wire logic                         srst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [indicator_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire indicator_pkg::net_status_s   net,
  input  wire indicator_pkg::switch_s       switches,
  input  wire logic [N_PORTS-1:0]           port_frame_ok,
  input  wire logic [N_PORTS-1:0]           port_frame_bad,
  input  wire logic [N_PORTS-1:0]           port_link_up,
  output indicator_pkg::led_s               leds,
  output logic      [N_PORTS-1:0]           port_line_error_led,
  output logic      [N_PORTS-1:0]           port_link_led
);
  import indicator_pkg::*;

  if (N_PORTS < 1 || N_PORTS > PORTS_MAX) begin : g_bad_ports
    $error("port count must be 1 to 8");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic               sampled;
    switch_s            snap;
    ctrl_s              ctrl;
    led_s               led;
    logic [N_PORTS-1:0] line_err;
    logic [N_PORTS-1:0] link;
    logic [31:0]        rdata;
    logic               slverr;
  } core_state_s;

  core_state_s st;
  core_state_s next_st;
  logic        blink;
  logic        changed;
  logic        num_bad;
  logic        setup;
  logic        wr_access;
  logic        hit;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] snap_word;

  blink_gen #(
    .HALF_CYC (BLINK_HALF)
  ) u_blink (
    .clk_sys (clk_sys),
    .srst    (srst),
    .blink   (blink)
  );

  // ----------------------------------------------------------------
  // derived conditions
  // ----------------------------------------------------------------
  // compare live switches against power-up copy
  assign changed = st.sampled && (switches != st.snap);
  assign num_bad = (st.ctrl.net_number < NET_NUM_MIN) ||
                   (st.ctrl.net_number > NET_NUM_MAX);

  assign setup     = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign hit       = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                     (paddr == ADDR_SNAP);

  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_SYS_ERR]   = st.ctrl.sys_error;
    ctrl_word[CTRL_SET_READY] = st.ctrl.setting_ready;
    ctrl_word[CTRL_SET_DONE]  = st.ctrl.setting_done;
    ctrl_word[CTRL_NUM_SET]   = st.ctrl.number_entered;
    ctrl_word[CTRL_NUM_LSB +: 8] = st.ctrl.net_number;
  end

  always_comb begin
    status_word = '0;
    status_word[STAT_LED_LSB +: 8]        = st.led;
    status_word[STAT_LERR_LSB +: N_PORTS] = st.line_err;
    status_word[STAT_LINK_LSB +: N_PORTS] = st.link;
    status_word[STAT_CHANGED]             = changed;
    status_word[STAT_SETMODE]             = st.snap.setting_mode;
  end

  always_comb begin
    snap_word = '0;
    snap_word[SNAP_STN_LSB +: 8] = st.snap.station;
    snap_word[SNAP_NET_LSB +: 8] = st.snap.netnum;
    snap_word[SNAP_MODE]         = st.snap.setting_mode;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;

    // one capture after reset release, then frozen
    if (!st.sampled) begin
      next_st.sampled = 1'b1;
      next_st.snap    = switches;
    end

    // read data prepared in setup, so access needs no wait
    if (setup) begin
      next_st.slverr = !hit;
      unique case (paddr)
        ADDR_CTRL:   next_st.rdata = ctrl_word;
        ADDR_STATUS: next_st.rdata = status_word;
        ADDR_SNAP:   next_st.rdata = snap_word;
        default:     next_st.rdata = RDATA_NONE;
      endcase
    end

    if (wr_access && paddr == ADDR_CTRL) begin
      next_st.ctrl.sys_error      = pwdata[CTRL_SYS_ERR];
      next_st.ctrl.setting_ready  = pwdata[CTRL_SET_READY];
      next_st.ctrl.setting_done   = pwdata[CTRL_SET_DONE];
      next_st.ctrl.number_entered = pwdata[CTRL_NUM_SET];
      next_st.ctrl.net_number     = pwdata[CTRL_NUM_LSB +: 8];
    end

    next_st.led.power_led = net.power_on;
    // run off on any network error
    next_st.led.run_led = net.run_ok && !net.net_error;

    // data link steady, flashing or dark
    if (net.link_active && net.cyclic_run) begin
      next_st.led.data_link_led = 1'b1;
    end else if (net.link_active) begin
      next_st.led.data_link_led = blink;
    end else begin
      next_st.led.data_link_led = 1'b0;
    end

    if (net.comm_error) begin
      next_st.led.net_error_led = 1'b1;
    end else if (changed) begin
      next_st.led.net_error_led = blink;
    end else begin
      next_st.led.net_error_led = 1'b0;
    end

    next_st.led.receive_activity_led  = net.rx_active;
    next_st.led.transmit_activity_led = net.tx_active;

    // mode is the one sampled at power-up, not the live switch
    if (st.snap.setting_mode) begin
      if (st.ctrl.setting_done) begin
        next_st.led.system_status_led_a = 1'b1;
      end else if (st.ctrl.setting_ready) begin
        next_st.led.system_status_led_a = blink;
      end else begin
        next_st.led.system_status_led_a = 1'b0;
      end
      // only a number actually entered can be out of range
      next_st.led.system_status_led_b = st.ctrl.number_entered && num_bad;
    end else begin
      next_st.led.system_status_led_a = !st.ctrl.sys_error;
      next_st.led.system_status_led_b = st.ctrl.sys_error;
    end

    // bad data wins when both arrive together
    for (int i = 0; i < N_PORTS; i++) begin
      if (port_frame_bad[i]) begin
        next_st.line_err[i] = 1'b1;
      end else if (port_frame_ok[i]) begin
        next_st.line_err[i] = 1'b0;
      end
    end

    next_st.link = port_link_up;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata              = st.rdata;
  assign pslverr             = st.slverr;
  assign pready              = 1'b1;
  assign leds                = st.led;
  assign port_line_error_led = st.line_err;
  assign port_link_led       = st.link;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  // the release edge still samples reset state, so wait for the snapshot
  default disable iff (srst || !st.sampled);

  sequence link_idle_s;
    net.link_active && !net.cyclic_run;
  endsequence

  sequence quiet_s;
    !net.comm_error && !changed;
  endsequence

  sequence set_mode_s;
    st.snap.setting_mode;
  endsequence

  sequence range_err_s;
    set_mode_s ##0 st.ctrl.number_entered && num_bad;
  endsequence

  power_led_a: assert property (
    net.power_on |=> leds.power_led)
    else $error("power led not lit with power on");

  run_led_a: assert property (
    net.net_error |=> !leds.run_led)
    else $error("run led lit during network error");

  dlink_on_a: assert property (
    net.link_active && net.cyclic_run |=> leds.data_link_led)
    else $error("data link led not steady on");

  dlink_flash_a: assert property (
    link_idle_s ##0 blink != $past(blink) ##1 link_idle_s
      |=> leds.data_link_led == $past(blink))
    else $error("data link led not following blink");

  dlink_off_a: assert property (
    !net.link_active |=> !leds.data_link_led)
    else $error("data link led lit without link");

  err_on_a: assert property (
    net.comm_error |=> leds.net_error_led)
    else $error("error led not steady on");

  err_flash_a: assert property (
    !net.comm_error && changed |=> leds.net_error_led == $past(blink))
    else $error("error led not flashing on switch change");

  station_hold_a: assert property (
    st.sampled |=> $stable(st.snap.station) [*2])
    else $error("station snapshot changed after power-up");

  err_dark_a: assert property (
    quiet_s |=> !leds.net_error_led)
    else $error("error led lit with nothing pending");

  rx_led_a: assert property (
    net.rx_active != leds.receive_activity_led
      |=> leds.receive_activity_led == $past(net.rx_active))
    else $error("receive led not following traffic");

  tx_led_a: assert property (
    net.tx_active != leds.transmit_activity_led
      |=> leds.transmit_activity_led == $past(net.tx_active))
    else $error("transmit led not following traffic");

  sts_a_normal_a: assert property (
    !st.snap.setting_mode |=> leds.system_status_led_a == !$past(st.ctrl.sys_error))
    else $error("status led a wrong in normal mode");

  sts_a_done_a: assert property (
    set_mode_s ##0 st.ctrl.setting_done |=> leds.system_status_led_a)
    else $error("status led a not steady after setting");

  sts_a_ready_a: assert property (
    set_mode_s ##0 !st.ctrl.setting_done && st.ctrl.setting_ready
      |=> leds.system_status_led_a == $past(blink))
    else $error("status led a not flashing when ready");

  sts_b_normal_a: assert property (
    !st.snap.setting_mode |=> leds.system_status_led_b == $past(st.ctrl.sys_error))
    else $error("status led b wrong in normal mode");

  sts_b_range_a: assert property (
    range_err_s |=> leds.system_status_led_b)
    else $error("status led b dark on bad network number");

  num_range_a: assert property (
    set_mode_s ##0 st.ctrl.number_entered &&
      st.ctrl.net_number >= NET_NUM_MIN && st.ctrl.net_number <= NET_NUM_MAX
      |=> !leds.system_status_led_b)
    else $error("status led b lit on valid network number");

  for (genvar i = 0; i < N_PORTS; i++) begin : g_port_chk
    line_err_set_a: assert property (
      port_frame_bad[i] |=> port_line_error_led[i])
      else $error("line error led not set on bad data");

    line_err_clr_a: assert property (
      port_frame_ok[i] && !port_frame_bad[i] |=> !port_line_error_led[i])
      else $error("line error led not cleared on good data");

    line_err_hold_a: assert property (
      !port_frame_ok[i] && !port_frame_bad[i] |=> $stable(port_line_error_led[i]))
      else $error("line error led changed with no data");

    link_led_a: assert property (
      port_link_up[i] |=> port_link_led[i])
      else $error("link led dark during link-up");
  end

  blink_half_a: assert property (
    blink != $past(blink) |=> blink == $past(blink))
    else $error("blink toggled on consecutive cycles");

  apb_err_a: assert property (
    setup && !hit ##1 psel && penable |-> pslverr)
    else $error("unmapped access not flagged");

endmodule

// ### testbench/lamp_observer.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// operator view of the lamps
// ----------------------------------------------------------------
module lamp_observer #(
  parameter int unsigned WIDTH  = 12,
  parameter int unsigned WINDOW = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             clear,
  input  wire logic [WIDTH-1:0] lamp,
  output logic [2*WIDTH-1:0]    cls
);
  int unsigned lit [WIDTH];

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < WIDTH; i++) begin
      lit[i] <= clear ? 0 : lit[i] + int'(lamp[i]);
    end
  end

  // 0 dark, 1 steady, 2 flashing; the window spans two blink periods
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      cls[2*i+:2] = (lit[i] == 0) ? 2'h0 : (lit[i] == WINDOW) ? 2'h1 : 2'h2;
    end
  end
endmodule

// ### testbench/fieldbus_status_indicator_logic_test.sv
`timescale 1ns/100ps
module fieldbus_status_indicator_logic_test;
  import indicator_pkg::*;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  localparam int unsigned HALF = 4;
  localparam int unsigned WIN  = 16;
  logic        clk_sys  = 1'b0;
  logic        srst     = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  net_status_s net      = 8'h00;
  switch_s     switches = {8'h12, 8'h05, 1'b0};
  switch_s     p_sw;
  logic [1:0]  pok      = 2'h0;
  logic [1:0]  pbad     = 2'h0;
  logic [1:0]  plink    = 2'h0;
  led_s        leds;
  logic [1:0]  lerr_led;
  logic [1:0]  link_led;
  logic        clear    = 1'b0;
  logic [23:0] cls;
  logic [31:0] rd;
  logic        er;
  logic [31:0] tab [8]  = '{32'h2, 32'h4, 32'h6, 32'h8, 32'h108, 32'hEF08, 32'hF008, 32'hFF0A};
  int          bad_count;
  int          num_checks;
  int          m_sys, m_ready, m_done, m_ent, m_num, m_mode, m_chg;
  int          m_lerr [2];

  always #10 clk_sys = ~clk_sys;

  indicator_core #(.N_PORTS(2), .BLINK_HALF(HALF)) DUT (
    .clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .net(net), .switches(switches), .port_frame_ok(pok), .port_frame_bad(pbad),
    .port_link_up(plink), .leds(leds), .port_line_error_led(lerr_led), .port_link_led(link_led)
  );

  lamp_observer #(.WIDTH(12), .WINDOW(WIN)) observer (
    .clk_sys(clk_sys), .clear(clear), .lamp({leds, lerr_led, link_led}), .cls(cls)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] cl(input logic on, input logic fl);
    return on ? 32'h1 : fl ? 32'h2 : 32'h0;
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      bad_count++;
      print_verdict();
    end
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_ctrl();
    apb(1'b1, ADDR_CTRL, 32'(m_num << 8) | 32'(m_ent << 3) | 32'(m_done << 2) | 32'(m_ready << 1) | 32'(m_sys));
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    p_sw = switches;
    {m_sys, m_ready, m_done, m_ent, m_num, m_chg} = '0;
    m_mode = int'(switches.setting_mode);
    m_lerr = '{0, 0};
  endtask

  task automatic port_event(input logic [1:0] ok, input logic [1:0] bd);
    @(posedge clk_sys);
    pok  <= ok;
    pbad <= bd;
    @(posedge clk_sys);
    pok  <= 2'h0;
    pbad <= 2'h0;
    for (int i = 0; i < 2; i++) begin
      m_lerr[i] = bd[i] ? 1 : ok[i] ? 0 : m_lerr[i];
    end
  endtask

  task automatic look();
    repeat (3) @(posedge clk_sys);
    clear <= 1'b1;
    @(posedge clk_sys);
    clear <= 1'b0;
    repeat (WIN) @(posedge clk_sys);
    #1;
    check("power", cls[23:22], cl(net.power_on, 1'b0));
    check("run", cls[21:20], cl(net.run_ok && !net.net_error, 1'b0));
    check("data link", cls[19:18], cl(net.link_active && net.cyclic_run, net.link_active));
    check("error", cls[17:16], cl(net.comm_error, m_chg != 0));
    check("receive", cls[15:14], cl(net.rx_active, 1'b0));
    check("transmit", cls[13:12], cl(net.tx_active, 1'b0));
    check("status a", cls[11:10], m_mode ? cl(m_done != 0, m_ready != 0) : cl(m_sys == 0, 1'b0));
    check("status b", cls[9:8], cl(m_mode ? (m_ent != 0 && (m_num < 1 || m_num > 239)) : m_sys != 0, 1'b0));
    check("line error 1", cls[7:6], cl(m_lerr[1] != 0, 1'b0));
    check("line error 0", cls[5:4], cl(m_lerr[0] != 0, 1'b0));
    check("link 1", cls[3:2], cl(plink[1], 1'b0));
    check("link 0", cls[1:0], cl(plink[0], 1'b0));
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h260A));
    do_reset();
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    check("unmapped error", 32'(er), 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, ADDR_SNAP, 32'hFFFFFFFF);
    apb(1'b0, ADDR_SNAP, 32'h0);
    check("snapshot", rd, 32'({p_sw.setting_mode, p_sw.netnum, p_sw.station}));
    check("snapshot error", 32'(er), 32'h0);
    $display("test registers done");
    for (int k = 0; k < 10; k++) begin
      @(posedge clk_sys);
      net   <= 8'($urandom);
      plink <= 2'($urandom);
      m_sys = int'($urandom % 2);
      wr_ctrl();
      look();
    end
    $display("test status done");
    port_event(2'b01, 2'b10);
    look();
    port_event(2'b11, 2'b01);
    look();
    port_event(2'b00, 2'b00);
    look();
    port_event(2'b11, 2'b00);
    look();
    $display("test ports done");
    // switch changes flash the error lamp; station copy stays
    for (int j = 0; j < 3; j++) begin
      @(posedge clk_sys);
      case (j)
        0: switches.station <= switches.station + 8'h01;
        1: switches.netnum <= switches.netnum + 8'h01;
        default: switches.setting_mode <= ~switches.setting_mode;
      endcase
      m_chg = 1;
      look();
      apb(1'b0, ADDR_SNAP, 32'h0);
      check("snapshot kept", rd[7:0], 32'(p_sw.station));
      @(posedge clk_sys);
      switches <= p_sw;
      m_chg = 0;
      look();
    end
    $display("test switches done");
    @(posedge clk_sys);
    switches.setting_mode <= 1'b1;
    do_reset();
    look();
    for (int c = 0; c < 8; c++) begin
      {m_num, m_ent, m_done, m_ready, m_sys} = {int'(tab[c][15:8]), int'(tab[c][3]), int'(tab[c][2]),
                                                int'(tab[c][1]), int'(tab[c][0])};
      wr_ctrl();
      look();
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("setting mode", 32'(rd[STAT_SETMODE]), 32'h1);
    $display("test setting mode done");
    print_verdict();
  end
endmodule
